// >>> hdl/tif_pkg.sv
// Package with register map, field positions and encodings of the timer interrupt flag and mask block.
package tif_pkg;

  // Register byte addresses on the APB bus.
  // The mask register's printed offset is not word aligned, so it is kept as a word index.
  localparam logic [11:0] TIF_MASK_IDX = 12'h06E;
  localparam logic [11:0] TIF_MASK_ADDR = {TIF_MASK_IDX[9:0], 2'b00};
  localparam logic [11:0] TIF_FLAG_ADDR = 12'h070;
  localparam logic [11:0] TIF_MODE_ADDR = 12'h074;
  localparam logic [11:0] TIF_CNT_ADDR = 12'h078;
  localparam logic [11:0] TIF_CMPA_ADDR = 12'h07C;
  localparam logic [11:0] TIF_CMPB_ADDR = 12'h080;
  localparam logic [11:0] TIF_IEN_ADDR = 12'h084;
  localparam logic [11:0] TIF_ICLR_ADDR = 12'h088;
  localparam logic [11:0] TIF_ISTAT_ADDR = 12'h08C;

  // Bit positions shared by the mask and flag registers.
  localparam int TIF_BIT_OVF = 0;
  localparam int TIF_BIT_CMPA = 1;
  localparam int TIF_BIT_CMPB = 2;
  localparam int TIF_NBITS = 3;

  // Reset values.
  localparam logic [2:0] TIF_MASK_RST = 3'h0;
  localparam logic [2:0] TIF_FLAG_RST = 3'h0;
  localparam logic [2:0] TIF_MODE_RST = 3'h0;

  // Counter landmarks.
  localparam logic [7:0] TIF_MAX = 8'hFF;
  localparam logic [7:0] TIF_BOTTOM = 8'h00;

  // Waveform generation modes.
  localparam logic [2:0] TIF_WGM_NORMAL = 3'h0;
  localparam logic [2:0] TIF_WGM_PC_FF = 3'h1;
  localparam logic [2:0] TIF_WGM_CTC = 3'h2;
  localparam logic [2:0] TIF_WGM_FAST_FF = 3'h3;
  localparam logic [2:0] TIF_WGM_PC_A = 3'h5;
  localparam logic [2:0] TIF_WGM_FAST_A = 3'h7;

  // Event sticky bits in the system interrupt status register.
  localparam int TIF_EV_IRQ = 0;
  localparam int TIF_EV_BADADDR = 1;
  localparam int TIF_NEV = 2;

endpackage

// >>> hdl/tif_evdet.sv
// Overflow and compare event detector for the 8-bit timer counter value.
`timescale 1ns/1ps
module tif_evdet
  import tif_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic [WIDTH-1:0] count_value, // Counter value, synchronised.
  input wire logic [WIDTH-1:0] cmp_a_value, // Compare A value.
  input wire logic [WIDTH-1:0] cmp_b_value, // Compare B value.
  input wire logic [2:0] wave_mode_sel, // Waveform generation mode.
  output logic ovf_ev, // One-cycle overflow event.
  output logic cmp_a_ev, // One-cycle compare A event.
  output logic cmp_b_ev // One-cycle compare B event.
);

  initial begin
    if (WIDTH != 8) $error("tif_evdet supports only an 8-bit counter");
  end

  logic [WIDTH-1:0] prev_cnt;
  logic next_ovf;
  logic next_a;
  logic next_b;
  logic changed;

  // Events fire once, on the cycle after the counter arrives at a value, so a stopped counter raises no repeat events.
  always_comb begin
    changed = (count_value != prev_cnt);
    next_a = changed && (count_value == cmp_a_value);
    next_b = changed && (count_value == cmp_b_value);
    case (wave_mode_sel)
      TIF_WGM_NORMAL, TIF_WGM_CTC, TIF_WGM_FAST_FF: next_ovf = changed && (count_value == TIF_MAX);
      TIF_WGM_PC_FF, TIF_WGM_PC_A: next_ovf = changed && (count_value == TIF_BOTTOM);
      TIF_WGM_FAST_A: next_ovf = changed && (count_value == cmp_a_value);
      default: next_ovf = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_cnt <= '0;
      ovf_ev <= 1'b0;
      cmp_a_ev <= 1'b0;
      cmp_b_ev <= 1'b0;
    end else begin
      prev_cnt <= count_value;
      ovf_ev <= next_ovf;
      cmp_a_ev <= next_a;
      cmp_b_ev <= next_b;
    end
  end

endmodule

// >>> hdl/tif_irq.sv
// Interrupt flag and mask logic of an 8-bit timer with an APB register slave.
`timescale 1ns/1ps
module tif_irq
  import tif_pkg::*;
#(
  parameter int CNT_WIDTH = 8
) (
  input wire logic pclk, // System clock, 50 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB byte strobes.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped address.
  input wire logic global_irq_enable, // Processor global interrupt enable.
  input wire logic [2:0] vector_ack, // Vector executed: bit 2 cmp B, 1 cmp A, 0 overflow.
  input wire logic force_cmp_a_strobe, // Software forced compare A strobe.
  input wire logic [CNT_WIDTH-1:0] count_value, // Counter value from the counting unit.
  output logic [2:0] irq_req, // Requests to the core: bit 2 cmp B, 1 cmp A, 0 overflow.
  output logic irq // System interrupt level.
);

  initial begin
    if (CNT_WIDTH != 8) $error("tif_irq supports only an 8-bit counter");
  end

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [CNT_WIDTH-1:0] cnt_s1;
  logic [CNT_WIDTH-1:0] cnt_s2;
  logic gie_s1;
  logic gie_s2;
  logic [2:0] ack_s1;
  logic [2:0] ack_s2;

  // The counter value comes from another timing source, so it is treated as asynchronous.
  // A multi-bit value may be caught mid-change; the event detector fires on any changed sample that matches, stable or not.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_s1 <= '0;
      cnt_s2 <= '0;
      gie_s1 <= 1'b0;
      gie_s2 <= 1'b0;
      ack_s1 <= 3'h0;
      ack_s2 <= 3'h0;
    end else begin
      cnt_s1 <= count_value;
      cnt_s2 <= cnt_s1;
      gie_s1 <= global_irq_enable;
      gie_s2 <= gie_s1;
      ack_s1 <= vector_ack;
      ack_s2 <= ack_s1;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [2:0] mask;
  logic [2:0] flags;
  logic [2:0] wave_mode_sel;
  logic [CNT_WIDTH-1:0] cmp_a_value;
  logic [CNT_WIDTH-1:0] cmp_b_value;
  logic [TIF_NEV-1:0] ev_en;
  logic [TIF_NEV-1:0] ev_stat;
  logic [2:0] next_mask;
  logic [2:0] next_flags;
  logic [2:0] next_mode;
  logic [CNT_WIDTH-1:0] next_cmpa;
  logic [CNT_WIDTH-1:0] next_cmpb;
  logic [TIF_NEV-1:0] next_ev_en;
  logic [TIF_NEV-1:0] next_ev_stat;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic next_pready;
  logic [2:0] next_irq_req;
  logic next_irq;
  logic ovf_ev;
  logic cmp_a_ev;
  logic cmp_b_ev;
  logic [2:0] set_ev;
  logic acc;
  logic wr;
  logic mapped;
  logic [2:0] w1c;
  logic [2:0] ack_prev;
  logic [2:0] ack_rise;
  logic irq_prev;

  function automatic logic is_mapped(input logic [11:0] a);
    case (a)
      TIF_MASK_ADDR, TIF_FLAG_ADDR, TIF_MODE_ADDR, TIF_CNT_ADDR, TIF_CMPA_ADDR,
      TIF_CMPB_ADDR, TIF_IEN_ADDR, TIF_ICLR_ADDR, TIF_ISTAT_ADDR: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  tif_evdet #(
    .WIDTH(CNT_WIDTH)
  ) u_evdet (
    .pclk(pclk),
    .presetn(presetn),
    .count_value(cnt_s2),
    .cmp_a_value(cmp_a_value),
    .cmp_b_value(cmp_b_value),
    .wave_mode_sel(wave_mode_sel),
    .ovf_ev(ovf_ev),
    .cmp_a_ev(cmp_a_ev),
    .cmp_b_ev(cmp_b_ev)
  );

  // ****************************************
  // Register next-state logic
  // ****************************************
  always_comb begin
    // Zero wait states: the access phase always completes on its first cycle.
    acc = psel && penable && pready;
    wr = acc && pwrite;
    mapped = is_mapped(paddr);
    ack_rise = ack_s2 & ~ack_prev;
    // The forced compare strobe never reaches the flags; only real matches do.
    set_ev = {cmp_b_ev, cmp_a_ev, ovf_ev};
    w1c = (wr && paddr == TIF_FLAG_ADDR && pstrb[0]) ? pwdata[2:0] : 3'h0;
    next_mask = mask;
    next_mode = wave_mode_sel;
    next_cmpa = cmp_a_value;
    next_cmpb = cmp_b_value;
    next_ev_en = ev_en;
    if (wr && pstrb[0]) begin
      case (paddr)
        TIF_MASK_ADDR: next_mask = pwdata[2:0];
        TIF_MODE_ADDR: next_mode = pwdata[2:0];
        TIF_CMPA_ADDR: next_cmpa = pwdata[CNT_WIDTH-1:0];
        TIF_CMPB_ADDR: next_cmpb = pwdata[CNT_WIDTH-1:0];
        TIF_IEN_ADDR: next_ev_en = pwdata[TIF_NEV-1:0];
        default: next_mask = mask;
      endcase
    end
    // Clears take only ones; a new event in the same cycle wins over either clear.
    next_flags = (flags & ~w1c & ~ack_rise) | set_ev;
    next_irq_req = flags & mask & {3{gie_s2}};
    next_ev_stat = ev_stat;
    if (wr && paddr == TIF_ICLR_ADDR && pstrb[0]) begin
      next_ev_stat = ev_stat & ~pwdata[TIF_NEV-1:0];
    end
    if ((|irq_req) && !irq_prev) begin
      next_ev_stat[TIF_EV_IRQ] = 1'b1;
    end
    if (acc && !mapped) begin
      next_ev_stat[TIF_EV_BADADDR] = 1'b1;
    end
    next_irq = |(next_ev_stat & next_ev_en);
    next_prdata = prdata;
    next_pslverr = 1'b0;
    next_pready = 1'b0;
    if (psel && !penable) begin
      next_pready = 1'b1;
      next_pslverr = !mapped;
      next_prdata = 32'h0;
      if (!pwrite) begin
        case (paddr)
          TIF_MASK_ADDR: next_prdata = {29'h0, mask};
          TIF_FLAG_ADDR: next_prdata = {29'h0, flags};
          TIF_MODE_ADDR: next_prdata = {29'h0, wave_mode_sel};
          TIF_CNT_ADDR: next_prdata = {24'h0, cnt_s2};
          TIF_CMPA_ADDR: next_prdata = {24'h0, cmp_a_value};
          TIF_CMPB_ADDR: next_prdata = {24'h0, cmp_b_value};
          TIF_IEN_ADDR: next_prdata = {30'h0, ev_en};
          TIF_ISTAT_ADDR: next_prdata = {30'h0, ev_stat};
          default: next_prdata = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= TIF_MASK_RST;
      flags <= TIF_FLAG_RST;
      wave_mode_sel <= TIF_MODE_RST;
      cmp_a_value <= '0;
      cmp_b_value <= '0;
      ev_en <= '0;
      ev_stat <= '0;
      ack_prev <= 3'h0;
      irq_prev <= 1'b0;
      irq_req <= 3'h0;
      irq <= 1'b0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      mask <= next_mask;
      flags <= next_flags;
      wave_mode_sel <= next_mode;
      cmp_a_value <= next_cmpa;
      cmp_b_value <= next_cmpb;
      ev_en <= next_ev_en;
      ev_stat <= next_ev_stat;
      ack_prev <= ack_s2;
      irq_prev <= |irq_req;
      irq_req <= next_irq_req;
      irq <= next_irq;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

endmodule

// >>> verif/tif_chk.sv
// Port checker of the timer interrupt flag and mask block.
`timescale 1ns/1ps
module tif_chk
  import tif_pkg::*;
(
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic psel, // Select.
  input wire logic penable, // Enable.
  input wire logic pwrite, // Direction.
  input wire logic [11:0] paddr, // Address.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pready, // Ready.
  input wire logic pslverr, // Error.
  input wire logic global_irq_enable, // Global enable.
  input wire logic [2:0] vector_ack, // Vector run.
  input wire logic [2:0] irq_req // Requests.
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing after setup");
  property p_acc; pready |-> psel && penable; endproperty
  a_acc: assert property (p_acc) else $error("ready outside access");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_zero;
    pready && !pwrite && (paddr == TIF_MASK_ADDR || paddr == TIF_FLAG_ADDR) |-> prdata[31:3] == 29'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("upper bits not zero");
  property p_gb; (!global_irq_enable)[*4] |-> !irq_req[2]; endproperty
  a_gb: assert property (p_gb) else $error("cmp b request without global");
  property p_ga; (!global_irq_enable)[*4] |-> !irq_req[1]; endproperty
  a_ga: assert property (p_ga) else $error("cmp a request without global");
  property p_go; (!global_irq_enable)[*4] |-> !irq_req[0]; endproperty
  a_go: assert property (p_go) else $error("ovf request without global");
  property p_ack; $rose(vector_ack[0]) |-> ##[1:6] !irq_req[0]; endproperty
  a_ack: assert property (p_ack) else $error("vector left ovf request");
endmodule
bind tif_irq tif_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .global_irq_enable(global_irq_enable),
  .vector_ack(vector_ack), .irq_req(irq_req));

// >>> verif/tif_core_model.sv
// Core model that runs the vector of every request it sees while ack_on is high.
`timescale 1ns/1ps
module tif_core_model (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic ack_on, // Vectors allowed.
  input wire logic [2:0] irq_req, // Requests.
  output logic [2:0] vector_ack // Vector running.
);
  // The vector stays up until the request drops, as a slow core would hold it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_ack <= 3'h0;
    end else begin
      vector_ack <= ack_on ? irq_req : 3'h0;
    end
  end
endmodule

// >>> verif/test_timer8_irq_flag_mask.sv
// Self-checking testbench of the timer interrupt flag and mask block.
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module test_timer8_irq_flag_mask
  import tif_pkg::*;
;
  // ****************
  // Stimulus
  // ****************
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, er, irq, ack_on = 1'b0, global_irq_enable = 1'b0, force_cmp_a_strobe = 1'b0;
  logic [2:0] vector_ack, irq_req;
  logic [7:0] count_value = 8'h0;
  int err_count = 0, compares = 0, cyc = 0;
  tif_irq dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .global_irq_enable(global_irq_enable), .vector_ack(vector_ack), .force_cmp_a_strobe(force_cmp_a_strobe),
    .count_value(count_value), .irq_req(irq_req), .irq(irq));
  tif_core_model core (.pclk(pclk), .presetn(presetn), .ack_on(ack_on), .irq_req(irq_req),
    .vector_ack(vector_ack));
  initial begin
    forever #10 pclk = ~pclk;
  end
  task automatic complete_run();
    if (err_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench's cycle ceiling ends a wait for a slave that never answers.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  // Flags land four edges after a count change, so six edges leave margin.
  task automatic setcnt(input logic [7:0] v);
    @(posedge pclk);
    count_value <= v;
    repeat (6) @(posedge pclk);
  endtask
  task automatic t_regs();
    rdchk(TIF_MASK_ADDR, 32'h0);
    rdchk(TIF_FLAG_ADDR, 32'h0);
    xfer(1'b1, TIF_MASK_ADDR, 32'hFFFFFFFF);
    rdchk(TIF_MASK_ADDR, 32'h7);
    pstrb <= 4'h0;
    xfer(1'b1, TIF_MASK_ADDR, 32'h0);
    pstrb <= 4'hF;
    rdchk(TIF_MASK_ADDR, 32'h7);
    rdchk(12'h0F0, 32'h0);
    `CHK(er, 1'b1)
    rdchk(TIF_ISTAT_ADDR, 32'h2);
    xfer(1'b1, TIF_ICLR_ADDR, 32'h2);
    rdchk(TIF_ISTAT_ADDR, 32'h0);
  endtask
  task automatic t_ovf();
    logic [7:0] tgt [8];
    tgt = '{8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h55, 8'h00, 8'h55, 8'h40};
    xfer(1'b1, TIF_CMPA_ADDR, 32'h40);
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, TIF_MODE_ADDR, 32'(i));
      setcnt(8'h20);
      xfer(1'b1, TIF_FLAG_ADDR, 32'h7);
      setcnt(tgt[i]);
      xfer(1'b0, TIF_FLAG_ADDR, 32'h0);
      `CHK(rd[0], 1'(i != 4 && i != 6))
    end
  endtask
  task automatic t_cmp();
    xfer(1'b1, TIF_MODE_ADDR, 32'h0);
    xfer(1'b1, TIF_CMPB_ADDR, 32'h41);
    setcnt(8'h20);
    xfer(1'b1, TIF_FLAG_ADDR, 32'h7);
    setcnt(8'h40);
    rdchk(TIF_FLAG_ADDR, 32'h2);
    setcnt(8'h41);
    rdchk(TIF_FLAG_ADDR, 32'h6);
    xfer(1'b1, TIF_FLAG_ADDR, 32'h2);
    rdchk(TIF_FLAG_ADDR, 32'h4);
    force_cmp_a_strobe <= 1'b1;
    setcnt(8'h41);
    force_cmp_a_strobe <= 1'b0;
    rdchk(TIF_FLAG_ADDR, 32'h4);
    rdchk(TIF_CNT_ADDR, 32'h41);
    rdchk(TIF_CMPB_ADDR, 32'h41);
    xfer(1'b1, TIF_FLAG_ADDR, 32'h7);
  endtask
  task automatic t_irq();
    xfer(1'b1, TIF_IEN_ADDR, 32'h1);
    global_irq_enable <= 1'b1;
    setcnt(8'hFF);
    repeat (3) @(posedge pclk);
    `CHK(irq_req, 3'h1)
    `CHK(irq, 1'b1)
    xfer(1'b1, TIF_IEN_ADDR, 32'h0);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    xfer(1'b1, TIF_MASK_ADDR, 32'h6);
    repeat (3) @(posedge pclk);
    `CHK(irq_req, 3'h0)
    xfer(1'b1, TIF_MASK_ADDR, 32'h7);
    setcnt(8'h40);
    setcnt(8'h41);
    global_irq_enable <= 1'b0;
    repeat (5) @(posedge pclk);
    `CHK(irq_req, 3'h0)
    global_irq_enable <= 1'b1;
    repeat (5) @(posedge pclk);
    `CHK(irq_req, 3'h7)
    xfer(1'b1, TIF_IEN_ADDR, 32'h1);
    xfer(1'b1, TIF_ICLR_ADDR, 32'h3);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    ack_on <= 1'b1;
    repeat (10) @(posedge pclk);
    `CHK(irq_req, 3'h0)
    rdchk(TIF_FLAG_ADDR, 32'h0);
    ack_on <= 1'b0;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_ovf();
    t_cmp();
    t_irq();
    complete_run();
  end
endmodule
